// file: design/swd_top.sv
// watchdog timer with AHB-Lite register slave
// ==========================================================
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "swd_map.svh"
module swd_top
  import swd_pkg::*;
#(
  parameter int TICK_DIV = `SWD_TICK_US * `SWD_CLK_MHZ
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_req,
  input wire logic wait_req,
  output logic tmo_out_n,
  output logic sys_rst_req_n
);
  // ==========================================================
  // parameter check
  if (TICK_DIV < 2)
  begin : g_tick_check
    $error("swd_top: TICK_DIV must be at least 2");
  end
  // ==========================================================
  // pin synchronisers for the power-mode indicators
  logic [1:0] slp_sync;
  logic [1:0] wt_sync;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slp_sync <= 2'b00;
      wt_sync <= 2'b00;
    end
    else
    begin
      slp_sync <= {slp_sync[0], sleep_req};
      wt_sync <= {wt_sync[0], wait_req};
    end
  end
  // ==========================================================
  // ahb address phase capture
  logic dp_wr;
  logic dp_rd;
  logic [7:0] dp_addr;
  wire ap_valid = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (hready)
    begin
      dp_wr <= ap_valid & hwrite;
      dp_rd <= ap_valid & ~hwrite;
      dp_addr <= haddr[7:0];
    end
  end
  wire wr_ctrl = dp_wr & (dp_addr == `SWD_OFS_CTRL);
  wire wr_svc = dp_wr & (dp_addr == `SWD_OFS_SVC);
  // ==========================================================
  // configuration; sel and timeout take one write only
  swd_cfg_s cfg;
  logic wdone;
  logic tmo_hit;
  wire [`SWD_TMO_W-1:0] wr_tmo = hwdata[`SWD_TMO_LSB +: `SWD_TMO_W];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg <= '{en: 1'b0, sel: 1'b0, slp: 1'b0, wait_susp: 1'b0, tmo: `SWD_TMO_RST};
      wdone <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // writing 0 to en cannot clear it
      cfg.en <= cfg.en | hwdata[`SWD_CTRL_EN];
      cfg.slp <= hwdata[`SWD_CTRL_SLP];
      cfg.wait_susp <= hwdata[`SWD_CTRL_WAIT];
      if (!wdone)
      begin
        cfg.sel <= hwdata[`SWD_CTRL_SEL];
        cfg.tmo <= wr_tmo;
        wdone <= 1'b1;
      end
    end
  end
  // ==========================================================
  // service sequence: key1 then key2 is one valid service
  swd_svc_e svc_st;
  logic svc_ok;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      svc_st <= SWD_IDLE;
      svc_ok <= 1'b0;
    end
    else
    begin
      svc_ok <= 1'b0;
      if (wr_svc)
      begin
        case (svc_st)
          SWD_IDLE: svc_st <= (hwdata == `SWD_SVC_KEY1) ? SWD_KEY : SWD_IDLE;
          SWD_KEY:
          begin
            svc_ok <= (hwdata == `SWD_SVC_KEY2);
            svc_st <= (hwdata == `SWD_SVC_KEY1) ? SWD_KEY : SWD_IDLE;
          end
          default: svc_st <= SWD_IDLE;
        endcase
      end
    end
  end
  // ==========================================================
  // countdown; suspended in either low-power state when enabled
  wire susp = (cfg.slp & slp_sync[1]) | (cfg.wait_susp & wt_sync[1]);
  wire run = cfg.en & ~susp & ~tmo_hit;
  logic tick;
  swd_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .tick(tick)
  );
  logic [`SWD_TMO_W-1:0] cnt;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= `SWD_TMO_RST;
      tmo_hit <= 1'b0;
    end
    else if (!cfg.en)
      // en and tmo may land in one write, so take the new timeout at once
      cnt <= (wr_ctrl && !wdone) ? wr_tmo : cfg.tmo;
    else if (svc_ok && !tmo_hit)
      cnt <= cfg.tmo;
    else if (tick)
    begin
      if (cnt == '0)
        tmo_hit <= 1'b1;
      else
        cnt <= cnt - 1'b1;
    end
  end
  // ==========================================================
  // outputs, sticky until reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tmo_out_n <= 1'b1;
      sys_rst_req_n <= 1'b1;
    end
    else
    begin
      tmo_out_n <= ~(tmo_hit & ~cfg.sel);
      sys_rst_req_n <= ~(tmo_hit & cfg.sel);
    end
  end
  // ==========================================================
  // read data: one wait state per read, always okay
  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat;
  always_comb
  begin
    rd_ctrl = 32'h0000_0000;
    rd_ctrl[`SWD_CTRL_EN] = cfg.en;
    rd_ctrl[`SWD_CTRL_SEL] = cfg.sel;
    rd_ctrl[`SWD_CTRL_SLP] = cfg.slp;
    rd_ctrl[`SWD_CTRL_WAIT] = cfg.wait_susp;
    rd_ctrl[`SWD_CTRL_LOCK] = wdone;
    rd_ctrl[`SWD_TMO_LSB +: `SWD_TMO_W] = cfg.tmo;
    rd_stat = 32'h0000_0000;
    rd_stat[`SWD_STAT_ACT] = cfg.en;
    rd_stat[`SWD_STAT_TMO] = tmo_hit;
    rd_stat[`SWD_STAT_WDONE] = wdone;
  end
  wire [31:0] rd_cnt = {24'h00_0000, cnt};
  // the wait state lets hrdata come from a flop and still show a write just before
  wire rd_load = dp_rd & ~hreadyout;
  wire [31:0] rd_mux = (dp_addr == `SWD_OFS_CTRL) ? rd_ctrl :
                       (dp_addr == `SWD_OFS_STAT) ? rd_stat :
                       (dp_addr == `SWD_OFS_CNT) ? rd_cnt : 32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= ~(ap_valid & ~hwrite);
      if (rd_load)
        hrdata <= rd_mux;
      hresp <= 1'b0;
    end
  end
endmodule : swd_top

// file: design/swd_map.svh
// register map, field positions, reset values and timing constants of the watchdog
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH
`define SWD_OFS_CTRL 8'h00
`define SWD_OFS_SVC 8'h04
`define SWD_OFS_STAT 8'h08
`define SWD_OFS_CNT 8'h0C
`define SWD_CTRL_EN 0
`define SWD_CTRL_SEL 1
`define SWD_CTRL_SLP 2
`define SWD_CTRL_WAIT 3
`define SWD_CTRL_LOCK 4
`define SWD_TMO_LSB 8
`define SWD_TMO_W 8
`define SWD_STAT_ACT 0
`define SWD_STAT_TMO 1
`define SWD_STAT_WDONE 2
`define SWD_SVC_KEY1 32'h0000_5555
`define SWD_SVC_KEY2 32'h0000_AAAA
`define SWD_TMO_RST 8'h01
`define SWD_TICK_US 1
`define SWD_CLK_MHZ 200
`endif

// file: design/swd_pkg.sv
// types shared by the watchdog files
package swd_pkg;
  typedef struct packed {
    logic en;
    logic sel;
    logic slp;
    logic wait_susp;
    logic [7:0] tmo;
  } swd_cfg_s;
  typedef enum logic [1:0] {
    SWD_IDLE,
    SWD_KEY,
    SWD_ARMED
  } swd_svc_e;
endpackage : swd_pkg

// file: design/swd_tick.sv
// tick divider: one-cycle enable pulse at the counting rate
`timescale 1ns/1ps
module swd_tick
  import swd_pkg::*;
#(
  parameter int DIV = 200
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt;
  wire last = (cnt == W'(DIV - 1));
  // a divider of one would leave a zero-width counter
  if (DIV < 2)
  begin : g_div_check
    $error("swd_tick: DIV must be at least 2");
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= run & last;
      if (!run || last)
        cnt <= '0;
      else
        cnt <= cnt + 1'b1;
    end
  end
endmodule : swd_tick

// file: bench/swd_asserts.sv
// checker for the watchdog outputs
`timescale 1ns/1ps
module swd_asserts
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic tmo_out_n,
  input wire logic sys_rst_req_n
);
  logic wp;
  logic act;
  wire quiet = tmo_out_n && sys_rst_req_n;
  // reads add a wait state, so an address phase counts only with hready high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp <= 1'b0;
      act <= 1'b0;
    end
    else if (hready)
    begin
      wp <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      act <= act || (wp && hwdata[0]);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // properties
  a_tmo_kept: assert property (!tmo_out_n |=> !tmo_out_n) else $error("tmo rose");
  a_rst_kept: assert property (!sys_rst_req_n |=> !sys_rst_req_n) else $error("req rose");
  a_one_out: assert property (tmo_out_n || sys_rst_req_n) else $error("both low");
  a_idle_quiet: assert property (!act |-> quiet) else $error("fall while idle");
  a_fall_late: assert property (!quiet && $past(quiet) |-> $past(act, 2)) else $error("early");
  a_svc_holds: assert property (quiet && hready && hsel && htrans[1] && hwrite
    && haddr[7:0] == 8'h04
    ##1 hwdata == 32'h0000_AAAA |=> quiet [*3]) else $error("fall after service");
endmodule : swd_asserts
bind swd_top swd_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hready, .hwrite,
  .hwdata,
  .tmo_out_n, .sys_rst_req_n);

// file: bench/tb_system_watchdog_timer.sv
// bench for the watchdog
`timescale 1ns/1ps
module tb_system_watchdog_timer;
  logic hclk, hresetn, hsel, hwrite, sleep_req, wait_req, hreadyout, hresp;
  logic tmo_out_n, sys_rst_req_n;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] t;
  int n_mismatch, n_compared;
  int m_en, m_sel, m_slp, m_wt, m_tmo, m_wd;
  swd_top #(.TICK_DIV(4)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sleep_req, .wait_req,
    .tmo_out_n, .sys_rst_req_n);
  initial
  begin
    hclk = 0;
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================
  // tasks
  task close_out;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, s);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task bound(input int i, lim);
    if (i >= lim)
    begin
      n_mismatch++;
      close_out;
    end
  endtask : bound
  task step;
    int i;
    @(posedge hclk);
    for (i = 0; hreadyout !== 1'b1 && i < 9; i++)
      @(posedge hclk);
    bound(i, 9);
  endtask : step
  // reference model of the control register, written from the rules
  task m_wr(input logic [31:0] d);
    m_en = m_en | d[0];
    m_slp = d[2];
    m_wt = d[3];
    if (m_wd == 0)
    begin
      m_sel = d[1];
      m_tmo = d[15:8];
      m_wd = 1;
    end
  endtask : m_wr
  function automatic logic [31:0] exp_ctrl();
    return {16'h0000, m_tmo[7:0], 3'b000, m_wd[0], m_wt[0], m_slp[0], m_sel[0], m_en[0]};
  endfunction : exp_ctrl
  // read data is taken at the edge that ends the data phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    step;
    htrans <= 2'b00;
    hwdata <= d;
    step;
    r = hrdata;
    chk("resp", 0, {31'h0, hresp});
    if (w && a == 8'h00)
      m_wr(d);
  endtask : xfer
  task idle(input int n, input logic [1:0] e);
    repeat (n)
    begin
      @(posedge hclk);
      chk("outs", {30'h0, e}, {30'h0, tmo_out_n, sys_rst_req_n});
    end
  endtask : idle
  // lo and hi bracket the edges seen before the fall, from (tmo+1) ticks
  task fall(input logic [1:0] e, input int lo, hi);
    int i;
    for (i = 0; tmo_out_n === 1'b1 && sys_rst_req_n === 1'b1 && i < hi; i++)
      @(posedge hclk);
    bound(i, hi);
    chk("early", 1, {31'h0, i >= lo});
    idle(1, e);
  endtask : fall
  task svc;
    xfer(1'b1, 8'h04, 32'h0000_5555);
    xfer(1'b1, 8'h04, 32'h0000_AAAA);
  endtask : svc
  task rst;
    hresetn <= 1'b0;
    m_en = 0;
    m_sel = 0;
    m_slp = 0;
    m_wt = 0;
    m_tmo = 1;
    m_wd = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : rst
  initial
  begin
    {hresetn, hsel, hwrite, sleep_req, wait_req, haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    t = 8'($urandom(58956) % 5 + 3);
    rst;
    xfer(1'b0, 8'h00, 0);
    chk("ctrl", exp_ctrl(), r);
    idle(40, 2'b11);
    sleep_req <= 1'b1;
    xfer(1'b1, 8'h00, {16'h0, t, 8'h0D});
    xfer(1'b1, 8'h00, 32'h0000_FF0E);
    xfer(1'b0, 8'h00, 0);
    chk("ctrl", exp_ctrl(), r);
    idle(100, 2'b11);
    xfer(1'b0, 8'h0C, 0);
    chk("cnt", {24'h00_0000, m_tmo[7:0]}, r);
    sleep_req <= 1'b0;
    wait_req <= 1'b1;
    idle(100, 2'b11);
    wait_req <= 1'b0;
    repeat (8)
    begin
      svc;
      idle(t, 2'b11);
    end
    fall(2'b01, 3 * t + 1, 4 * t + 8);
    xfer(1'b0, 8'h08, 0);
    chk("stat", 32'h0000_0007, r);
    svc;
    idle(20, 2'b01);
    rst;
    sleep_req <= 1'b1;
    wait_req <= 1'b1;
    xfer(1'b1, 8'h00, 32'h0000_0303);
    xfer(1'b0, 8'h10, 0);
    chk("adr", 0, r);
    fall(2'b10, 12, 24);
    close_out;
  end
endmodule : tb_system_watchdog_timer
